// >>> hdl/qdc_defs.vh
// Function
// - Word is start, op, address, data.
// - Store writes data to nonvolatile register.
// - Store leaves outputs and states unchanged.
// - Busy low from command until store done.
// - Store ignored while all channels inactive.
// - Write loads volatile register at D0 edge.
// - Top address bit selects mute/shutdown register.
// - Upper bits mute, lower bits shut down.
// - Register write leaves nonvolatile memory alone.
// - Read shifts register out after address.
// - Data output floats when select rises.
// - Read changes nothing; busy stays high.
// - Load copies nonvolatile to volatile at A0.
// - Load keeps nonvolatile; busy stays high.
// - Shut down channel output floats.
// - Muted channel drives low reference level.
// - External mute input mutes all channels.
// - Store re-enabled after mute register write; here only by a write that changes the register value.
// - Power-on loads codes then mute register.
// - Muted and interface off during init.
// - Op codes store, write, read, load.
// - Address 100 selects mute/shutdown register.
// - Bits captured MSB first on rising edges.
// - Interface off while select high.
`ifndef QDC_DEFS_VH
`define QDC_DEFS_VH
`define QDC_WORD_BITS 14
`define QDC_CMD_BITS 6
`define QDC_OP_STORE 2'h0
`define QDC_OP_WRITE 2'h1
`define QDC_OP_READ 2'h2
`define QDC_OP_LOAD 2'h3
`define QDC_ADDR_MS 3'h4
`define QDC_MS_RESET 8'h00
`define QDC_CODE_RESET 8'h00
`define QDC_CLK_HZ 10000000
`define QDC_STORE_MS 13
`define QDC_STORE_CYC ((`QDC_CLK_HZ / 1000) * `QDC_STORE_MS)
`define QDC_INIT_US 80
`define QDC_INIT_CYC ((`QDC_CLK_HZ / 1000000) * `QDC_INIT_US)
`endif

// >>> hdl/qdc_sync.v
`timescale 1ns/100ps
module qdc_sync #(
    parameter W = 4
) (
    input wire clock,
    input wire rst_n,
    input wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= {W{1'b0}};
            s2_q <= {W{1'b0}};
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
        end
    end
    assign q = s2_q;
endmodule

// >>> hdl/qdc_nvm.v
`timescale 1ns/100ps
`include "qdc_defs.vh"
// Nonvolatile array of five bytes with a timed write.
module qdc_nvm #(
    parameter STORE_CYC = `QDC_STORE_CYC
) (
    input wire clock,
    input wire rst_n,
    input wire wr,
    input wire [2:0] wr_addr,
    input wire [7:0] wr_data,
    input wire [2:0] rd_addr,
    output wire [7:0] rd_data,
    output wire busy
);
    reg [7:0] mem [0:4];
    reg [23:0] cnt_q;
    reg [2:0] pa_q;
    reg [7:0] pd_q;
    integer i;
    assign rd_data = (rd_addr <= 3'h4) ? mem[rd_addr] : 8'h00;
    assign busy = (cnt_q != 24'h000000);
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 24'h000000;
            pa_q <= 3'h0;
            pd_q <= 8'h00;
            for (i = 0; i < 5; i = i + 1) begin
                mem[i] <= `QDC_CODE_RESET;
            end
        end else if (wr && !busy) begin
            pa_q <= wr_addr;
            pd_q <= wr_data;
            cnt_q <= STORE_CYC[23:0];
        end else if (busy) begin
            cnt_q <= cnt_q - 24'h000001;
            if (cnt_q == 24'h000001 && pa_q <= 3'h4) begin
                mem[pa_q] <= pd_q;
            end
        end
    end
endmodule

// >>> hdl/qdc_ctrl.v
`timescale 1ns/100ps
`include "qdc_defs.vh"
// Quad DAC serial command controller.
module qdc_ctrl #(
    parameter STORE_CYC = `QDC_STORE_CYC,
    parameter INIT_CYC = `QDC_INIT_CYC
) (
    input wire clock,
    input wire rst_n,
    input wire sclk,
    input wire cs_n,
    input wire sdi,
    input wire mute_in,
    output reg sdo_o,
    output reg sdo_oe,
    output wire store_ready_n_busy,
    output wire [31:0] dac_code,
    output wire [3:0] dac_mute,
    output wire [3:0] dac_shdn,
    output wire init_done
);
    localparam S_INIT = 2'h0;
    localparam S_IDLE = 2'h1;
    wire [3:0] syn;
    reg sclk_d_q;
    reg [1:0] st_q;
    reg [13:0] cnt_q;
    reg [2:0] ia_q;
    reg [13:0] sh_q;
    reg [3:0] nb_q;
    reg rd_q;
    reg [7:0] rsh_q;
    reg [7:0] code_q [0:3];
    reg [7:0] ms_q;
    reg lock_q;
    reg pend_q;
    reg nv_wr;
    reg [2:0] nv_wa;
    reg [7:0] nv_wd;
    wire [7:0] nv_rd;
    wire nv_busy;
    wire [2:0] nv_ra;
    wire s_clk;
    wire s_cs_n;
    wire s_din;
    wire s_mute;
    wire rise;
    wire [13:0] w;
    wire [1:0] op;
    wire [2:0] ad;
    qdc_sync #(.W(4)) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .d({sclk, cs_n, sdi, mute_in}),
        .q(syn)
    );
    assign s_clk = syn[3];
    assign s_cs_n = syn[2];
    assign s_din = syn[1];
    assign s_mute = syn[0];
    assign rise = s_clk && !sclk_d_q && !s_cs_n && (st_q == S_IDLE);
    assign w = {sh_q[12:0], s_din};
    // Op and address sit in the low bits of w while the address edge is taken.
    assign op = w[4:3];
    assign ad = w[2:0];
    assign nv_ra = (st_q == S_INIT) ? ia_q : ((nb_q == 4'h5) ? w[2:0] : sh_q[2:0]);
    assign init_done = (st_q == S_IDLE);
    // A pending store holds busy low from the address edge until the write starts.
    assign store_ready_n_busy = !(nv_busy | pend_q);
    qdc_nvm #(.STORE_CYC(STORE_CYC)) u_nvm (
        .clock(clock),
        .rst_n(rst_n),
        .wr(nv_wr),
        .wr_addr(nv_wa),
        .wr_data(nv_wd),
        .rd_addr(nv_ra),
        .rd_data(nv_rd),
        .busy(nv_busy)
    );
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_ch
            assign dac_code[8*g+7:8*g] = code_q[g];
            // Muted output goes to low_reference_level; code is kept.
            assign dac_mute[g] = ms_q[4+g] | s_mute | !init_done;
            assign dac_shdn[g] = ms_q[g] & init_done;
        end
    endgenerate
    // The store command is latched at the address edge so busy drops there.
    always @* begin
        nv_wr = 1'b0;
        nv_wa = 3'h0;
        nv_wd = 8'h00;
        if (rise && nb_q == 4'hD && pend_q) begin
            nv_wr = 1'b1;
            nv_wa = w[10:8];
            nv_wd = w[7:0];
        end
    end
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sclk_d_q <= 1'b0;
            st_q <= S_INIT;
            cnt_q <= 14'h0000;
            ia_q <= 3'h0;
            sh_q <= 14'h0000;
            nb_q <= 4'h0;
            rd_q <= 1'b0;
            rsh_q <= 8'h00;
            ms_q <= `QDC_MS_RESET;
            lock_q <= 1'b0;
            pend_q <= 1'b0;
            sdo_o <= 1'b0;
            sdo_oe <= 1'b0;
            code_q[0] <= `QDC_CODE_RESET;
            code_q[1] <= `QDC_CODE_RESET;
            code_q[2] <= `QDC_CODE_RESET;
            code_q[3] <= `QDC_CODE_RESET;
        end else begin
            sclk_d_q <= s_clk;
            case (st_q)
                S_INIT: begin
                    // Spread the five loads over the init time; mute/shutdown last.
                    if (cnt_q >= INIT_CYC[13:0] / 14'd5) begin
                        cnt_q <= 14'h0000;
                        if (ia_q == `QDC_ADDR_MS) begin
                            ms_q <= nv_rd;
                            lock_q <= all_off_v(nv_rd);
                            st_q <= S_IDLE;
                        end else begin
                            code_q[ia_q[1:0]] <= nv_rd;
                            ia_q <= ia_q + 3'h1;
                        end
                    end else begin
                        cnt_q <= cnt_q + 14'h0001;
                    end
                end
                S_IDLE: begin
                    if (s_cs_n) begin
                        nb_q <= 4'h0;
                        rd_q <= 1'b0;
                        pend_q <= 1'b0;
                        sdo_oe <= 1'b0;
                    end else if (rise) begin
                        sh_q <= w;
                        if (nb_q == 4'h0 && !s_din) begin
                            nb_q <= 4'h0;
                        end else if (nb_q != 4'hE) begin
                            nb_q <= nb_q + 4'h1;
                        end
                        if (rd_q) begin
                            sdo_o <= rsh_q[7];
                            rsh_q <= {rsh_q[6:0], 1'b0};
                        end
                        if (nb_q == 4'h5) begin
                            if (op == `QDC_OP_READ) begin
                                rd_q <= 1'b1;
                                sdo_oe <= 1'b1;
                                sdo_o <= nv_rd[7];
                                rsh_q <= {nv_rd[6:0], 1'b0};
                            end else if (op == `QDC_OP_STORE) begin
                                pend_q <= !lock_q;
                            end else if (op == `QDC_OP_LOAD) begin
                                if (ad == `QDC_ADDR_MS) begin
                                    ms_q <= nv_rd;
                                    // Loading an all-off pattern locks stores; only a write unlocks.
                                    if (all_off_v(nv_rd)) begin
                                        lock_q <= 1'b1;
                                    end
                                end else if (!ad[2]) begin
                                    code_q[ad[1:0]] <= nv_rd;
                                end
                            end
                        end
                        if (nb_q == 4'hD) begin
                            pend_q <= 1'b0;
                        end
                        if (nb_q == 4'hD && w[12:11] == `QDC_OP_WRITE) begin
                            if (w[10]) begin
                                ms_q <= w[7:0];
                                if (w[7:0] != ms_q) begin
                                    lock_q <= all_off_v(w[7:0]);
                                end
                            end else begin
                                code_q[w[9:8]] <= w[7:0];
                            end
                        end
                    end
                end
                default: st_q <= S_INIT;
            endcase
        end
    end
    function all_off_v;
        input [7:0] v;
        begin
            all_off_v = ((v[7:4] | v[3:0]) == 4'hF);
        end
    endfunction
endmodule

// >>> dv/qdc_host.sv
`timescale 1ns/100ps
module qdc_host (
    input wire clock,
    input wire sdo_o,
    input wire sdo_oe,
    input wire store_ready_n_busy,
    output logic sclk,
    output logic cs_n,
    output logic sdi
);
    // A released line shows the inverse, so a float never reads as good data.
    wire line = sdo_oe ? sdo_o : ~sdo_o;
    initial {sclk, cs_n, sdi} = 3'h2;
    task automatic half;
        repeat (4) @(negedge clock);
    endtask
    task automatic xfer(input logic [13:0] w, input int n, output logic [7:0] rd);
        int i;
        i = 0;
        while (store_ready_n_busy !== 1'b1 && i < 2000) begin
            @(negedge clock);
            i++;
        end
        cs_n = 1'b0;
        half();
        for (i = 0; i < n; i++) begin
            sdi = w[13 - i];
            half();
            if (i > 5) rd = {rd[6:0], line};
            sclk = 1'b1;
            half();
            sclk = 1'b0;
        end
        half();
        cs_n = 1'b1;
        sdi = 1'b0;
        // Select stays high a while so the block sees back-to-back words apart.
        half();
    endtask
endmodule

// >>> dv/qdc_ctrl_monitor.sv
`timescale 1ns/100ps
module qdc_mon (
    input wire clock,
    input wire rst_n,
    input wire cs_n,
    input wire mute_in,
    input wire sdo_oe,
    input wire store_ready_n_busy,
    input wire [31:0] dac_code,
    input wire [3:0] dac_mute,
    input wire [3:0] dac_shdn,
    input wire init_done
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence busy_hold;
        !store_ready_n_busy [*8];
    endsequence
    busy_span_a: assert property ($fell(store_ready_n_busy) |-> busy_hold ##[1:1000] store_ready_n_busy)
        else $error("store busy span wrong");
    init_mute_a: assert property (!init_done |-> dac_mute == 4'hF)
        else $error("not muted during init");
    idle_float_a: assert property (!init_done |-> !sdo_oe)
        else $error("data out driven during init");
    oe_off_a: assert property (cs_n [*5] |-> !sdo_oe)
        else $error("data out driven with select high");
    oe_cause_a: assert property ($rose(sdo_oe) |-> !cs_n)
        else $error("data out enabled without select");
    hold_a: assert property ((cs_n && init_done) [*5] |=> $stable(dac_code) && $stable(dac_shdn))
        else $error("state changed while deselected");
    store_keep_a: assert property (!store_ready_n_busy |-> $stable(dac_code) && $stable(dac_shdn))
        else $error("store changed outputs");
    mute_in_a: assert property (mute_in [*4] |-> dac_mute == 4'hF)
        else $error("mute input ignored");
endmodule

// >>> dv/tb_qdc_ctrl.sv
`timescale 1ns/100ps
module tb_qdc_ctrl;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic mute_in = 1'b0;
    wire sclk, cs_n, sdi, sdo_o, sdo_oe, rdy, init_done;
    wire [31:0] dac_code;
    wire [3:0] dac_mute, dac_shdn;
    logic [7:0] rd;
    int n_errors = 0;
    int checks = 0;
    int g;
    always #50 clock = ~clock;
    // Short store and init counts keep the run brief; timing still scales from them.
    qdc_ctrl #(.STORE_CYC(50), .INIT_CYC(20)) DUT (.clock(clock), .rst_n(rst_n), .sclk(sclk),
        .cs_n(cs_n), .sdi(sdi), .mute_in(mute_in), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
        .store_ready_n_busy(rdy), .dac_code(dac_code), .dac_mute(dac_mute),
        .dac_shdn(dac_shdn), .init_done(init_done));
    qdc_host host (.clock(clock), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .store_ready_n_busy(rdy),
        .sclk(sclk), .cs_n(cs_n), .sdi(sdi));
    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic cmd(input logic [1:0] op, input logic [2:0] a, input logic [7:0] d);
        host.xfer({1'b1, op, a, d}, 14, rd);
    endtask
    initial begin
        repeat (4) @(negedge clock);
        rst_n = 1'b1;
        for (g = 0; g < 100 && init_done !== 1'b1; g++) @(negedge clock);
        chk(init_done, 1'b1);
        chk({dac_mute, dac_shdn, dac_code}, 40'h0);
        for (g = 0; g < 4; g++) cmd(2'h1, g[2:0], 8'hA0 + g[7:0]);
        chk(dac_code, 32'hA3A2A1A0);
        cmd(2'h1, 3'h4, 8'h12);
        chk({dac_mute, dac_shdn}, 8'h12);
        cmd(2'h1, 3'h4, 8'h00);
        cmd(2'h0, 3'h1, 8'h55);
        chk({rdy, dac_code}, {1'b0, 32'hA3A2A1A0});
        cmd(2'h2, 3'h1, 8'h00);
        chk({rd, rdy}, {8'h55, 1'b1});
        chk(sdo_oe, 1'b0);
        cmd(2'h3, 3'h1, 8'h00);
        chk({dac_code[15:8], rdy}, {8'h55, 1'b1});
        host.xfer({3'h5, 3'h2, 8'h00}, 10, rd);
        chk(dac_code[23:16], 8'hA2);
        cmd(2'h0, 3'h4, 8'h0F);
        cmd(2'h3, 3'h4, 8'h00);
        chk(dac_shdn, 4'hF);
        cmd(2'h0, 3'h0, 8'h77);
        cmd(2'h2, 3'h0, 8'h00);
        chk(rd, 8'h00);
        cmd(2'h1, 3'h4, 8'h00);
        cmd(2'h0, 3'h0, 8'h77);
        cmd(2'h2, 3'h0, 8'h00);
        chk(rd, 8'h77);
        mute_in = 1'b1;
        repeat (5) @(negedge clock);
        chk(dac_mute, 4'hF);
        mute_in = 1'b0;
        repeat (5) @(negedge clock);
        chk({dac_mute, dac_code[7:0]}, {4'h0, 8'hA0});
        end_sim();
    end
    initial begin
        #2000000;
        n_errors++;
        end_sim();
    end
endmodule
bind qdc_ctrl qdc_mon mon (.clock(clock), .rst_n(rst_n), .cs_n(cs_n), .mute_in(mute_in),
    .sdo_oe(sdo_oe), .store_ready_n_busy(store_ready_n_busy), .dac_code(dac_code),
    .dac_mute(dac_mute), .dac_shdn(dac_shdn), .init_done(init_done));
